// >>> hw/adc_seq_params.svh
// Behaviour
// - writing one to the trigger starts a conversion; bit stays high, hardware clears it at the end of a single-mode conversion
// - a channel change during a conversion takes effect only in its last converter cycle
// - free-run repeats conversions after a software trigger, ignoring the done flag
// - divider counts while enabled and is held in reset while disabled
// - a single-ended conversion starts on the next converter clock rising edge
// - sampling at 1.5 cycles normally, at 13.5 cycles for the first conversion
// - completion writes the result, sets the done flag, clears trigger in single mode
// - free-run restarts immediately after completion with the trigger held high
// - lengths: 25 extended, 13 single-ended, 13 or 14 differential
// - differential conversions align automatically to the half-rate sync clock
// - software differential start takes 13 cycles if sync low, 14 if high
// - every auto-restarted differential conversion takes 14 cycles
// - selection writes go to a buffer copied until start, then frozen
// - copying resumes in the last converter cycle before the done flag sets
// - with boundary-scan enabled, analog function on port F bits 7:4 is overridden
// - in free-run the already-started result keeps the old channel
// - a single-ended input above the reference reads as full scale
// - selections do not take effect while the converter is disabled
// - reading the low byte blocks result updates until the high byte is read
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// register indices on the plain register port
`define ADDR_CONTROL_STATUS 2'h0
`define ADDR_INPUT_SELECT 2'h1
`define ADDR_RESULT_LOW 2'h2
`define ADDR_RESULT_HIGH 2'h3

// converter_control_status fields
`define CTRL_ENABLE_BIT 7
`define CTRL_TRIGGER_BIT 6
`define CTRL_FREE_RUN_BIT 5
`define CTRL_DONE_BIT 4
`define CTRL_DIV_MSB 2
`define CTRL_DIV_LSB 0

// input_select_register fields
`define SEL_REF_MSB 7
`define SEL_REF_LSB 6
`define SEL_CHAN_MSB 4
`define SEL_CHAN_LSB 0

// reset values
`define RESET_CHAN 5'h00
`define RESET_REF 2'h0
`define RESET_DIV 3'h0
`define RESET_RESULT 10'h000

// conversion timing counted in half converter clocks from the start edge
`define EXT_SAMPLE_HALF 8'h1B
`define EXT_LEN_HALF 8'h32
`define NORM_SAMPLE_HALF 8'h03
`define NORM_LEN_HALF 8'h1A
`define DIFF_LATE_SAMPLE_HALF 8'h05
`define DIFF_LATE_LEN_HALF 8'h1C
`define LAST_CYCLE_HALVES 8'h02

// channel codes at or above this are differential pairs
`define DIFF_CHAN_FIRST 5'h08
`define FULL_SCALE_CODE 10'h3FF
`define PORT_F_ALL_ANALOG 8'hFF
`define PORT_F_SCAN_MASK 8'h0F

`endif

// >>> hw/adc_seq_pkg.sv
package adc_seq_pkg;

  // one-hot sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;

  typedef logic [2:0] div_sel_t;
  typedef logic [7:0] half_count_t;

endpackage : adc_seq_pkg

// >>> hw/adc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module adc_pin_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // asynchronous pin and its filtered level
  input wire logic pin_in,
  output logic level_out
);

  logic meta_reg;
  logic s2_reg;
  logic s3_reg;

  // three stages; the first is only read by the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end

endmodule : adc_pin_sync
`default_nettype wire

// >>> hw/adc_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire div_sel_t div_sel,
  // converter clock edges as one-cycle ticks
  output logic rise_tick,
  output logic fall_tick
);

  logic [6:0] cnt_reg;

  // last count of a power-of-two ratio; select 0 and 1 both divide by two
  function automatic logic [6:0] last_count(input div_sel_t sel);
    case (sel)
      3'h0: last_count = 7'h01;
      3'h1: last_count = 7'h01;
      3'h2: last_count = 7'h03;
      3'h3: last_count = 7'h07;
      3'h4: last_count = 7'h0F;
      3'h5: last_count = 7'h1F;
      3'h6: last_count = 7'h3F;
      default: last_count = 7'h7F;
    endcase
  endfunction : last_count

  // held in reset while disabled so the first edge has a known phase
  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      cnt_reg <= 7'h00;
    end else if (cnt_reg >= last_count(div_sel)) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

  // ticks mark the rising edge at wrap and the falling edge at half way
  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      rise_tick <= 1'b0;
      fall_tick <= 1'b0;
    end else begin
      rise_tick <= (cnt_reg == last_count(div_sel));
      fall_tick <= (cnt_reg == (last_count(div_sel) >> 1));
    end
  end

endmodule : adc_clock_divider
`default_nettype wire

// >>> hw/adc_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int RESULT_W = 10
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // analog front end
  input wire logic [RESULT_W-1:0] sar_result,
  input wire logic over_range,
  output logic [4:0] active_channel,
  output logic [1:0] active_reference,
  output logic sample_hold,
  output logic conversion_busy,
  output logic half_rate_sync_clock,
  // port F analog function enables and scan pin
  input wire logic jtag_enable,
  output logic [7:0] upper_port_f_lines
);

  seq_state_t state_reg;
  logic enable_reg;
  logic trigger_reg;
  logic free_run_reg;
  logic done_reg;
  div_sel_t div_sel_reg;
  logic [4:0] chan_buf_reg;
  logic [1:0] ref_buf_reg;
  logic sel_lock_reg;
  logic first_pending_reg;
  logic result_lock_reg;
  logic diff_conv_reg;
  logic [RESULT_W-1:0] result_reg;
  half_count_t hcnt_reg;
  half_count_t samp_target_reg;
  half_count_t len_target_reg;
  logic rise_tick;
  logic fall_tick;
  logic jtag_level;

  // differential pairs sit above the single-ended codes
  function automatic logic is_differential(input logic [4:0] chan);
    is_differential = (chan >= `DIFF_CHAN_FIRST);
  endfunction : is_differential

  adc_clock_divider u_divider (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(enable_reg),
    .div_sel(div_sel_reg),
    .rise_tick(rise_tick),
    .fall_tick(fall_tick)
  );

  adc_pin_sync u_scan_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(jtag_enable),
    .level_out(jtag_level)
  );

  // register port decode
  logic wr_ctrl, wr_sel, rd_low, rd_high;
  assign wr_ctrl = reg_wr && (reg_addr == `ADDR_CONTROL_STATUS);
  assign wr_sel = reg_wr && (reg_addr == `ADDR_INPUT_SELECT);
  assign rd_low = reg_rd && (reg_addr == `ADDR_RESULT_LOW);
  assign rd_high = reg_rd && (reg_addr == `ADDR_RESULT_HIGH);

  // sequencing events
  half_count_t hcnt_inc;
  logic start_req;
  logic finish;
  logic restart;
  logic chan_diff;
  assign hcnt_inc = hcnt_reg + 8'h01;
  assign chan_diff = is_differential(active_channel);
  assign start_req = (state_reg == ST_IDLE) && enable_reg && trigger_reg && rise_tick;
  assign finish = (state_reg == ST_CONV) && rise_tick && (hcnt_inc == len_target_reg);
  assign restart = finish && free_run_reg;

  // control bits; a write of one to the trigger only sets it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_reg <= 1'b0;
      free_run_reg <= 1'b0;
      div_sel_reg <= `RESET_DIV;
    end else if (wr_ctrl) begin
      enable_reg <= reg_wdata[`CTRL_ENABLE_BIT];
      free_run_reg <= reg_wdata[`CTRL_FREE_RUN_BIT];
      div_sel_reg <= reg_wdata[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
    end
  end

  // trigger stays high through conversions; a write that enables and triggers at once must not be lost
  always_ff @(posedge ref_clk) begin
    if (rst || (!enable_reg && !(wr_ctrl && reg_wdata[`CTRL_ENABLE_BIT]))) begin
      trigger_reg <= 1'b0;
    end else if (wr_ctrl && reg_wdata[`CTRL_TRIGGER_BIT]) begin
      trigger_reg <= 1'b1;
    end else if (finish && !free_run_reg) begin
      trigger_reg <= 1'b0;
    end
  end

  // done flag: completion wins over a clearing write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if (wr_ctrl && reg_wdata[`CTRL_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // half-rate clock follows converter rising edges, parked low when disabled
  always_ff @(posedge ref_clk) begin
    if (rst || !enable_reg) begin
      half_rate_sync_clock <= 1'b0;
    end else if (rise_tick) begin
      half_rate_sync_clock <= !half_rate_sync_clock;
    end
  end

  // first conversion after enabling is the long one
  always_ff @(posedge ref_clk) begin
    if (rst || !enable_reg) begin
      first_pending_reg <= 1'b1;
    end else if (start_req) begin
      first_pending_reg <= 1'b0;
    end
  end

  // sequencer state and timing targets in half converter clocks
  always_ff @(posedge ref_clk) begin
    if (rst || !enable_reg) begin
      state_reg <= ST_IDLE;
      hcnt_reg <= 8'h00;
      samp_target_reg <= `NORM_SAMPLE_HALF;
      len_target_reg <= `NORM_LEN_HALF;
      diff_conv_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            state_reg <= ST_CONV;
            hcnt_reg <= 8'h00;
            diff_conv_reg <= chan_diff;
            if (first_pending_reg) begin
              samp_target_reg <= `EXT_SAMPLE_HALF;
              len_target_reg <= `EXT_LEN_HALF;
            end else if (chan_diff && half_rate_sync_clock) begin
              samp_target_reg <= `DIFF_LATE_SAMPLE_HALF;
              len_target_reg <= `DIFF_LATE_LEN_HALF;
            end else begin
              samp_target_reg <= `NORM_SAMPLE_HALF;
              len_target_reg <= `NORM_LEN_HALF;
            end
          end
        end
        ST_CONV: begin
          if (restart) begin
            // the restart lands on a high half-rate edge, so differential runs long
            hcnt_reg <= 8'h00;
            diff_conv_reg <= chan_diff;
            samp_target_reg <= chan_diff ? `DIFF_LATE_SAMPLE_HALF : `NORM_SAMPLE_HALF;
            len_target_reg <= chan_diff ? `DIFF_LATE_LEN_HALF : `NORM_LEN_HALF;
          end else if (finish) begin
            state_reg <= ST_IDLE;
            hcnt_reg <= 8'h00;
          end else if (rise_tick || fall_tick) begin
            hcnt_reg <= hcnt_inc;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // busy and sample strobe to the front end
  always_ff @(posedge ref_clk) begin
    if (rst || !enable_reg) begin
      conversion_busy <= 1'b0;
      sample_hold <= 1'b0;
    end else begin
      conversion_busy <= (state_reg == ST_CONV) ? !(finish && !free_run_reg) : start_req;
      sample_hold <= (state_reg == ST_CONV) && (rise_tick || fall_tick) && (hcnt_inc == samp_target_reg);
    end
  end

  // selection lock: set at start, released for the last converter cycle
  always_ff @(posedge ref_clk) begin
    if (rst || !enable_reg) begin
      sel_lock_reg <= 1'b0;
    end else if (start_req || restart) begin
      sel_lock_reg <= 1'b1;
    end else if ((state_reg == ST_CONV) && (hcnt_reg >= len_target_reg - `LAST_CYCLE_HALVES)) begin
      sel_lock_reg <= 1'b0;
    end
  end

  // software always writes the buffer, never the active selection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chan_buf_reg <= `RESET_CHAN;
      ref_buf_reg <= `RESET_REF;
    end else if (wr_sel) begin
      chan_buf_reg <= reg_wdata[`SEL_CHAN_MSB:`SEL_CHAN_LSB];
      ref_buf_reg <= reg_wdata[`SEL_REF_MSB:`SEL_REF_LSB];
    end
  end

  // active selection copies the buffer only while enabled and unlocked
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_channel <= `RESET_CHAN;
      active_reference <= `RESET_REF;
    end else if (enable_reg && !sel_lock_reg && !start_req && !restart) begin
      active_channel <= chan_buf_reg;
      active_reference <= ref_buf_reg;
    end
  end

  // reading the low byte freezes the pair until the high byte is read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_lock_reg <= 1'b0;
    end else if (rd_high) begin
      result_lock_reg <= 1'b0;
    end else if (rd_low) begin
      result_lock_reg <= 1'b1;
    end
  end

  // a result finishing while blocked is dropped; the done flag still sets
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_reg <= `RESET_RESULT;
    end else if (finish && !result_lock_reg) begin
      result_reg <= (over_range && !diff_conv_reg) ? `FULL_SCALE_CODE : sar_result;
    end
  end

  // scan interface takes the upper four analog inputs of port F
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      upper_port_f_lines <= `PORT_F_ALL_ANALOG;
    end else begin
      upper_port_f_lines <= jtag_level ? `PORT_F_SCAN_MASK : `PORT_F_ALL_ANALOG;
    end
  end

  // read data stand one cycle after the strobe; unmapped bits read zero
  always_ff @(posedge ref_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `ADDR_CONTROL_STATUS: reg_rdata <= {enable_reg, trigger_reg, free_run_reg, done_reg, 1'b0, div_sel_reg};
        `ADDR_INPUT_SELECT: reg_rdata <= {ref_buf_reg, 1'b0, chan_buf_reg};
        `ADDR_RESULT_LOW: reg_rdata <= result_reg[7:0];
        `ADDR_RESULT_HIGH: reg_rdata <= {6'h00, result_reg[RESULT_W-1:8]};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // checks on the sequencing
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_finish_single;
    finish && !free_run_reg;
  endsequence
  sequence s_finish_free;
    finish && free_run_reg;
  endsequence

  property p_trigger_held;
    (state_reg == ST_CONV) |-> trigger_reg;
  endproperty
  a_trigger_held: assert property (p_trigger_held) else $error("trigger low during conversion");
  property p_single_end;
    s_finish_single |=> !trigger_reg && done_reg && (state_reg == ST_IDLE);
  endproperty
  a_single_end: assert property (p_single_end) else $error("single completion wrong");
  property p_free_restart;
    s_finish_free |=> trigger_reg && (state_reg == ST_CONV) && (hcnt_reg == 8'h00);
  endproperty
  a_free_restart: assert property (p_free_restart) else $error("free-run did not restart");
  property p_div_held;
    !enable_reg ##1 !enable_reg |-> !rise_tick && !fall_tick;
  endproperty
  a_div_held: assert property (p_div_held) else $error("divider ran while disabled");
  property p_start_edge;
    $rose(conversion_busy) |-> $past(rise_tick) && $past(trigger_reg);
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("start off converter edge");
  property p_first_long;
    start_req && first_pending_reg |=> (len_target_reg == `EXT_LEN_HALF) && (samp_target_reg == `EXT_SAMPLE_HALF);
  endproperty
  a_first_long: assert property (p_first_long) else $error("first conversion not extended");
  property p_diff_late;
    start_req && !first_pending_reg && chan_diff && half_rate_sync_clock |=> (len_target_reg == `DIFF_LATE_LEN_HALF);
  endproperty
  a_diff_late: assert property (p_diff_late) else $error("late differential not 14 cycles");
  property p_restart_diff;
    restart && chan_diff |=> (len_target_reg == `DIFF_LATE_LEN_HALF) && (samp_target_reg == `DIFF_LATE_SAMPLE_HALF);
  endproperty
  a_restart_diff: assert property (p_restart_diff) else $error("restarted differential not 14 cycles");
  property p_sel_frozen;
    sel_lock_reg || !enable_reg |=> $stable(active_channel) && $stable(active_reference);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen) else $error("selection moved while locked");
  property p_result_blocked;
    result_lock_reg |=> $stable(result_reg);
  endproperty
  a_result_blocked: assert property (p_result_blocked) else $error("result changed while blocked");
  property p_scan_override;
    jtag_level |=> (upper_port_f_lines[7:4] == 4'h0);
  endproperty
  a_scan_override: assert property (p_scan_override) else $error("port F upper lines not overridden");

endmodule : adc_conversion_sequencer
`default_nettype wire

// >>> test/adc_front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_front_end_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // sequencer side
  input wire logic sample_hold,
  input wire logic conversion_busy,
  input wire logic [4:0] active_channel,
  input wire logic [1:0] active_reference,
  // bench request: input above the reference
  input wire logic over_req,
  // result back to the sequencer
  output logic [9:0] sar_result,
  output logic over_range
);
  logic [9:0] held_reg;
  logic [9:0] noise_reg;
  logic valid_reg;

  // hold the selection seen at the sample point; values are exact, so no gain settling
  // or reference switch error is modelled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      valid_reg <= 1'b0;
      held_reg <= 10'h000;
    end else if (sample_hold) begin
      valid_reg <= 1'b1;
      held_reg <= {active_reference, active_channel, 3'h5};
    end else if (!conversion_busy) begin
      valid_reg <= 1'b0;
    end
  end

  // outside a conversion the value means nothing, so it keeps moving
  always_ff @(posedge ref_clk) begin
    noise_reg <= rst ? 10'h2A5 : noise_reg + 10'h137;
  end

  assign sar_result = valid_reg ? held_reg : noise_reg;
  // input above reference saturates the converter
  assign over_range = valid_reg & over_req;
endmodule : adc_front_end_model
`default_nettype wire

// >>> test/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", name, exp, got); end end
module adc_conversion_sequencer_tb;
  logic ref_clk, rst, reg_wr, reg_rd, over_range, sample_hold, conversion_busy;
  logic half_rate_sync_clock, jtag_enable, over_req;
  logic [1:0] reg_addr, active_reference;
  logic [7:0] reg_wdata, reg_rdata, upper_port_f_lines;
  logic [9:0] sar_result;
  logic [4:0] active_channel;
  int n_mismatch = 0;
  int check_count = 0;
  integer seed = 32'h7197;

  adc_conversion_sequencer #(.RESULT_W(10)) dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sar_result(sar_result), .over_range(over_range), .active_channel(active_channel),
    .active_reference(active_reference), .sample_hold(sample_hold), .conversion_busy(conversion_busy),
    .half_rate_sync_clock(half_rate_sync_clock), .jtag_enable(jtag_enable),
    .upper_port_f_lines(upper_port_f_lines));

  adc_front_end_model fe (.ref_clk(ref_clk), .rst(rst), .sample_hold(sample_hold),
    .conversion_busy(conversion_busy), .active_channel(active_channel),
    .active_reference(active_reference), .over_req(over_req), .sar_result(sar_result),
    .over_range(over_range));

  // free-running system clock
  always #10 ref_clk = ~ref_clk;

  // result the front end should hand back for a selection
  function automatic logic [9:0] exp_res(input logic [1:0] rf, input logic [4:0] ch);
    return {rf, ch, 3'h5};
  endfunction : exp_res

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // write the control byte, count cycles until busy shows
  task automatic start(input logic [7:0] c, output int lat);
    wr(2'h0, c);
    lat = 0;
    while (conversion_busy !== 1'b1 && lat < 600) begin
      tick();
      lat++;
    end
    if (conversion_busy !== 1'b1) n_mismatch++;
  endtask : start

  // cycles from start to the sample pulse and to the end of busy
  task automatic finish(output int ts, output int tl);
    ts = 0;
    tl = 0;
    while (conversion_busy === 1'b1 && tl < 3000) begin
      tick();
      tl++;
      if (sample_hold === 1'b1) ts = tl;
    end
    if (conversion_busy === 1'b1) n_mismatch++;
  endtask : finish

  task automatic wait_sample(output int n);
    n = 0;
    do begin
      tick();
      n++;
    end while (sample_hold !== 1'b1 && n < 3000);
    if (sample_hold !== 1'b1) n_mismatch++;
  endtask : wait_sample

  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // hang guard, well above the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    int lat, ts, tl, i, ratio;
    logic [7:0] d;
    logic [31:0] r;
    logic [4:0] ch_b, ch_c;
    logic [1:0] rf;
    logic [9:0] e;
    ref_clk = 1'b0;
    rst = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    jtag_enable = 1'b0;
    over_req = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(2'h0, d);
    `CHK("ctrl_idle", 8'h00, d)
    `CHK("port_f_idle", 8'hFF, upper_port_f_lines)
    // first conversion after enabling; a fast converter clock keeps the run short and only
    // timing is judged, not resolution
    r = $random(seed);
    rf = r[5:4];
    ch_b = {2'b00, r[2:0]};
    wr(2'h1, {rf, 1'b0, ch_b});
    start(8'hC2, lat);
    finish(ts, tl);
    `CHK("ext_sample", 54, ts)
    `CHK("ext_len", 100, tl)
    rd(2'h0, d);
    `CHK("ctrl_done", 8'h92, d)
    e = exp_res(rf, ch_b);
    rd(2'h2, d);
    `CHK("res_low", e[7:0], d)
    rd(2'h3, d);
    `CHK("res_high", {6'h00, e[9:8]}, d)
    // channel change while converting
    ch_c = ch_b ^ 5'h04;
    wr(2'h0, 8'h92);
    start(8'hC2, lat);
    rd(2'h0, d);
    `CHK("ctrl_busy", 8'hC2, d)
    repeat (4) tick(); // one converter cycle before a new selection
    wr(2'h1, {rf, 1'b0, ch_c});
    `CHK("chan_locked", ch_b, active_channel)
    finish(ts, tl);
    `CHK("chan_after", ch_c, active_channel)
    rd(2'h2, d);
    `CHK("res_low_old", e[7:0], d)
    rd(2'h3, d);
    `CHK("res_high_old", {6'h00, e[9:8]}, d)
    // every divider ratio, normal single-ended conversions
    for (i = 0; i < 8; i++) begin
      ratio = (i < 2) ? 2 : (1 << i);
      wr(2'h0, {5'b10010, i[2:0]});
      start({5'b11000, i[2:0]}, lat);
      `CHK("start_delay", 1'b1, (lat <= ratio))
      finish(ts, tl);
      `CHK("norm_len", 13 * ratio, tl)
      `CHK("norm_sample", 3 * ratio / 2, ts)
    end
    // differential, single then free-running
    wr(2'h0, 8'h92);
    wr(2'h1, 8'h49);
    start(8'hC2, lat);
    finish(ts, tl);
    `CHK("diff_len", 1'b1, ((tl == 52 && ts == 6) || (tl == 56 && ts == 10)))
    wr(2'h0, 8'h92);
    start(8'hE2, lat);
    wait_sample(ts);
    wait_sample(ts);
    `CHK("auto_period", 56, ts)
    wr(2'h1, 8'h4A);
    rd(2'h0, d);
    `CHK("free_ctrl", 8'h70, d & 8'h70)
    wait_sample(ts);
    `CHK("free_chan", 5'h0A, active_channel)
    wr(2'h0, 8'h82);
    finish(ts, tl);
    rd(2'h0, d);
    `CHK("free_stop", 8'h92, d)
    // result lock between low and high byte reads
    wr(2'h0, 8'h92);
    wr(2'h1, 8'h03);
    start(8'hC2, lat);
    finish(ts, tl);
    e = exp_res(2'h0, 5'h03);
    rd(2'h2, d);
    `CHK("lock_low", e[7:0], d)
    wr(2'h1, 8'hC6);
    start(8'hC2, lat);
    finish(ts, tl);
    rd(2'h0, d);
    `CHK("lock_done", 8'h92, d)
    rd(2'h3, d);
    `CHK("lock_high", {6'h00, e[9:8]}, d)
    // input above reference
    over_req <= 1'b1;
    wr(2'h0, 8'h92);
    start(8'hC2, lat);
    finish(ts, tl);
    rd(2'h2, d);
    `CHK("over_low", 8'hFF, d)
    rd(2'h3, d);
    `CHK("over_high", 8'h03, d)
    over_req <= 1'b0;
    // selection held off while disabled, extended conversion after re-enable
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h05);
    repeat (8) tick();
    `CHK("chan_disabled", 5'h06, active_channel)
    `CHK("ref_disabled", 2'h3, active_reference)
    `CHK("half_rate_off", 1'b0, half_rate_sync_clock)
    wr(2'h0, 8'h82);
    repeat (8) tick();
    `CHK("chan_enabled", 5'h05, active_channel)
    `CHK("ref_enabled", 2'h0, active_reference)
    start(8'hC2, lat);
    finish(ts, tl);
    `CHK("reenable_len", 100, tl)
    // scan takes over the upper port lines
    jtag_enable <= 1'b1;
    repeat (8) tick();
    `CHK("port_f_scan", 8'h0F, upper_port_f_lines)
    jtag_enable <= 1'b0;
    repeat (8) tick();
    `CHK("port_f_back", 8'hFF, upper_port_f_lines)
    stop_test();
  end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
